// ---- adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
  // register indexes as printed; byte address is four times the index
  localparam logic [9:0]  IDX_RESULT      = 10'h01E;
  localparam logic [9:0]  IDX_CONV_CTRL   = 10'h01F;
  localparam logic [9:0]  IDX_PIN_CFG     = 10'h09F;
  localparam logic [9:0]  IDX_PERIPH_FLAG = 10'h00C;
  localparam logic [9:0]  IDX_PERIPH_EN   = 10'h08C;
  localparam logic [9:0]  IDX_IRQ_CTRL    = 10'h00B;

  // conversion_control fields
  localparam int          CLK_SEL_LSB     = 6;
  localparam int          CHAN_LSB        = 3;
  localparam int          GO_BIT          = 2;
  localparam int          POWER_BIT       = 0;
  // pin_configuration field sits in bits 2..0
  localparam int          PIN_ROLE_LSB    = 0;
  // done flag / enable in the peripheral registers, enables in irq control
  localparam int          DONE_BIT        = 6;
  localparam int          PERIPH_EN_BIT   = 6;
  localparam int          GLOBAL_EN_BIT   = 7;

  // reset values
  localparam logic [7:0]  CONV_CTRL_RST   = 8'h00;
  localparam logic [2:0]  PIN_CFG_RST     = 3'h0;
  localparam logic [7:0]  RESULT_RST      = 8'h00;

  // conversion clock codes and bit periods in oscillator periods
  localparam logic [1:0]  CLK_SEL_RC      = 2'h3;
  localparam int          TAD_TOSC_0      = 2;
  localparam int          TAD_TOSC_1      = 8;
  localparam int          TAD_TOSC_2      = 32;
  localparam logic [3:0]  HALF_TAD_0      = 4'(TAD_TOSC_0 / 2);
  localparam logic [3:0]  HALF_TAD_1      = 4'(TAD_TOSC_1 / 2);
  localparam logic [3:0]  HALF_TAD_2      = 4'(TAD_TOSC_2 / 2);

  // sequencing in half bit periods: 9.5 periods per result, 2 periods rest
  localparam logic [4:0]  CONV_HALVES     = 5'd19;
  localparam logic [4:0]  FIRST_RESOLVE   = 5'd4;
  localparam logic [4:0]  HOLDOFF_HALVES  = 5'd4;
  localparam logic [7:0]  SMALL_PKG_MASK  = 8'h1F;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_HOLDOFF} conv_st_t;
endpackage : adc_ctrl_pkg

// ---- sar_adc_control.sv ----
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// What this block does, and what software must do around it
// R1: converts selected input to 8-bit unsigned result
// R2: sample-hold feeds SAR, one bit at a time
// R3: reference selectable: supply or reference pin
// R4: sleep conversion only with private RC clock
// R5: clock select field in control bits 7-6
// R6: channel select bits 5-3 pick one of eight
// R7: channels 5-7 only in large package
// R8: writing go with power on starts conversion
// R9: hardware clears go at completion
// R10: power bit enables converter, clear shuts off
// R11: unimplemented bits read zero, ignore writes
// R12: pin role field sets analog/digital/reference pins
// R13: analog pins routed to converter, others digital
// R14: software configures pins before powering converter
// R15: software waits acquisition time before go
// R16: bit period derived from selected conversion clock
// R17: two bit periods rest before next acquisition
// R18: done flag set; interrupt when all enables set
// R19: software polls go or takes interrupt
// R20: software reads result, clears done flag
// R21: codes give 2, 8, 32 Tosc or RC
// R22: full conversion takes 9.5 bit periods
// R23: clearing go aborts, result keeps old value
// R24: sleep without RC aborts, powers off, bit stays
// R25: result, go clear, done flag same cycle
module sar_adc_control (
  input  wire logic        hclk,           // system clock, 100 MHz
  input  wire logic        hresetn,        // async reset, active low
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // word only
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready
  output logic      [31:0] hrdata,         // read data
  output logic             hreadyout,      // always ready
  output logic             hresp,          // always okay
  input  wire logic        cmp_in,         // comparator: input >= trial code
  input  wire logic        rc_clk_in,      // private rc oscillator
  input  wire logic        sleep_mode,     // core asleep
  input  wire logic        large_pkg,      // eight channel package
  output logic      [7:0]  analog_pin_en,  // per channel analog routing
  output logic      [2:0]  channel_select, // mux select
  output logic             chan_present,   // selected channel bonded out
  output logic             ref_from_pin,   // reference from reference pin
  output logic             conv_power_on,  // converter powered
  output logic             sample_hold,    // high holds the sample
  output logic      [7:0]  dac_code,       // current trial code
  output logic             conv_irq        // converter interrupt request
);

  typedef struct packed {
    adc_ctrl_pkg::conv_st_t st;
    logic [1:0]             conv_clock_select;
    logic [2:0]             chan;
    logic                   go;
    logic                   power;
    logic [2:0]             pin_role_select;
    logic [7:0]             conversion_result;
    logic                   flag;
    logic                   irq_en;
    logic                   periph_en;
    logic                   global_en;
    logic [7:0]             sar;
    logic [7:0]             probe;
    logic [4:0]             half_cnt;
    logic [3:0]             div_cnt;
    logic                   cmp_s1;
    logic                   cmp_s2;
    logic                   rc_s1;
    logic                   rc_s2;
    logic                   rc_s3;
    logic                   wr_pend;
    logic [9:0]             wr_idx;
    logic [31:0]            rdata;
  } state_t;

  state_t     s_reg;
  state_t     s_next;
  logic       tick;
  logic       done_evt;
  logic       abort_evt;
  logic       sleep_abort;
  logic       taken;
  logic [3:0] half_lim;
  logic [7:0] final_code;
  logic [7:0] role_mask;
  logic       role_ref;
  logic [9:0] rd_idx;

  // pin roles: analog channel mask and reference source per code
  always_comb begin
    role_mask = 8'h00;
    role_ref  = 1'b0;
    case (s_reg.pin_role_select)
      3'h0: begin role_mask = 8'hFF; role_ref = 1'b0; end       // R12
      3'h1: begin role_mask = 8'hF7; role_ref = 1'b1; end       // R12
      3'h2: begin role_mask = 8'h1F; role_ref = 1'b0; end       // R12
      3'h3: begin role_mask = 8'h17; role_ref = 1'b1; end       // R12
      3'h4: begin role_mask = 8'h0B; role_ref = 1'b0; end       // R12
      3'h5: begin role_mask = 8'h03; role_ref = 1'b1; end       // R12
      default: begin role_mask = 8'h00; role_ref = 1'b0; end    // R12
    endcase
  end

  // half bit period length per clock code; rc uses both edges instead
  always_comb begin
    case (s_reg.conv_clock_select)
      2'h0:    half_lim = adc_ctrl_pkg::HALF_TAD_0;             // R21
      2'h1:    half_lim = adc_ctrl_pkg::HALF_TAD_1;             // R21
      default: half_lim = adc_ctrl_pkg::HALF_TAD_2;             // R21
    endcase
  end

  assign sleep_abort = sleep_mode && (s_reg.conv_clock_select != adc_ctrl_pkg::CLK_SEL_RC);  // R4
  assign tick = (s_reg.conv_clock_select == adc_ctrl_pkg::CLK_SEL_RC)
              ? (s_reg.rc_s2 ^ s_reg.rc_s3)
              : (s_reg.div_cnt == half_lim - 4'h1);             // R16
  assign final_code = (s_reg.cmp_s2 ? s_reg.sar : (s_reg.sar & ~s_reg.probe));
  assign taken = hsel && htrans[1] && hready;
  assign rd_idx = haddr[11:2];

  // next state: bus writes first, then the sequencer so hardware wins
  always_comb begin
    s_next        = s_reg;
    done_evt      = 1'b0;
    abort_evt     = 1'b0;
    s_next.cmp_s1 = cmp_in;
    s_next.cmp_s2 = s_reg.cmp_s1;
    s_next.rc_s1  = rc_clk_in;
    s_next.rc_s2  = s_reg.rc_s1;
    s_next.rc_s3  = s_reg.rc_s2;
    s_next.div_cnt = tick ? 4'h0 : s_reg.div_cnt + 4'h1;
    // data phase of a write
    if (s_reg.wr_pend) begin
      case (s_reg.wr_idx)
        adc_ctrl_pkg::IDX_CONV_CTRL: begin
          s_next.conv_clock_select = hwdata[adc_ctrl_pkg::CLK_SEL_LSB +: 2];  // R5
          s_next.chan  = hwdata[adc_ctrl_pkg::CHAN_LSB +: 3];                 // R6
          s_next.power = hwdata[adc_ctrl_pkg::POWER_BIT];                     // R10
          // go only takes a one while the converter was already powered or go was already set
          s_next.go = hwdata[adc_ctrl_pkg::GO_BIT] && (s_reg.power || s_reg.go);  // R8
        end
        adc_ctrl_pkg::IDX_PIN_CFG:
          s_next.pin_role_select = hwdata[adc_ctrl_pkg::PIN_ROLE_LSB +: 3];   // R11
        adc_ctrl_pkg::IDX_RESULT:
          s_next.conversion_result = hwdata[7:0];
        adc_ctrl_pkg::IDX_PERIPH_FLAG:
          s_next.flag = hwdata[adc_ctrl_pkg::DONE_BIT];                      // R20
        adc_ctrl_pkg::IDX_PERIPH_EN:
          s_next.irq_en = hwdata[adc_ctrl_pkg::DONE_BIT];
        adc_ctrl_pkg::IDX_IRQ_CTRL: begin
          s_next.periph_en = hwdata[adc_ctrl_pkg::PERIPH_EN_BIT];
          s_next.global_en = hwdata[adc_ctrl_pkg::GLOBAL_EN_BIT];
        end
        default: ;
      endcase
    end
    // conversion sequencer counting in half bit periods
    case (s_reg.st)
      adc_ctrl_pkg::ST_IDLE: begin
        if (s_reg.go && s_reg.power && !sleep_abort) begin       // R8
          s_next.st       = adc_ctrl_pkg::ST_CONV;
          s_next.sar      = 8'h80;
          s_next.probe    = 8'h80;
          s_next.half_cnt = 5'd0;
          s_next.div_cnt  = 4'h0;
        end
      end
      adc_ctrl_pkg::ST_CONV: begin
        if (!s_next.go || !s_reg.power || sleep_abort) begin    // R23 R24
          abort_evt       = 1'b1;
          s_next.go       = 1'b0;
          s_next.st       = adc_ctrl_pkg::ST_HOLDOFF;
          s_next.half_cnt = 5'd0;
          s_next.div_cnt  = 4'h0;
        end else if (tick) begin
          s_next.half_cnt = s_reg.half_cnt + 5'd1;
          // resolve one bit at each tick with an even half_cnt from 4 to 18
          if (s_reg.half_cnt >= adc_ctrl_pkg::FIRST_RESOLVE && !s_reg.half_cnt[0]) begin  // R2
            s_next.sar   = final_code | (s_reg.probe >> 1);
            s_next.probe = s_reg.probe >> 1;
          end
          if (s_reg.half_cnt == adc_ctrl_pkg::CONV_HALVES - 5'd1) begin   // R22
            done_evt                 = 1'b1;
            s_next.conversion_result = final_code;              // R1 R25
            s_next.go                = 1'b0;                    // R9
            s_next.flag              = 1'b1;                    // R18
            s_next.st                = adc_ctrl_pkg::ST_HOLDOFF;
            s_next.half_cnt          = 5'd0;
          end
        end
      end
      adc_ctrl_pkg::ST_HOLDOFF: begin
        // a new go is kept but waits for the rest period to end
        if (tick) begin
          s_next.half_cnt = s_reg.half_cnt + 5'd1;
          if (s_reg.half_cnt == adc_ctrl_pkg::HOLDOFF_HALVES - 5'd1) begin  // R17
            s_next.st = adc_ctrl_pkg::ST_IDLE;
          end
        end
      end
      default: s_next.st = adc_ctrl_pkg::ST_IDLE;
    endcase
    // address phase: latch writes, answer reads from the updated copy
    s_next.wr_pend = taken && hwrite;
    if (taken && hwrite) begin
      s_next.wr_idx = rd_idx;
    end
    if (taken && !hwrite) begin
      s_next.rdata = 32'h0000_0000;                             // unmapped reads zero
      case (rd_idx)
        adc_ctrl_pkg::IDX_CONV_CTRL:
          s_next.rdata[7:0] = {s_next.conv_clock_select, s_next.chan, s_next.go,
                               1'b0, s_next.power};             // R11
        adc_ctrl_pkg::IDX_PIN_CFG:     s_next.rdata[7:0] = {5'h00, s_next.pin_role_select};  // R11
        adc_ctrl_pkg::IDX_RESULT:      s_next.rdata[7:0] = s_next.conversion_result;
        adc_ctrl_pkg::IDX_PERIPH_FLAG: s_next.rdata[adc_ctrl_pkg::DONE_BIT] = s_next.flag;
        adc_ctrl_pkg::IDX_PERIPH_EN:   s_next.rdata[adc_ctrl_pkg::DONE_BIT] = s_next.irq_en;
        adc_ctrl_pkg::IDX_IRQ_CTRL: begin
          s_next.rdata[adc_ctrl_pkg::PERIPH_EN_BIT] = s_next.periph_en;
          s_next.rdata[adc_ctrl_pkg::GLOBAL_EN_BIT] = s_next.global_en;
        end
        default: ;
      endcase
    end
  end

  // one register for all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg                   <= '0;
      s_reg.st                <= adc_ctrl_pkg::ST_IDLE;
      s_reg.conv_clock_select <= adc_ctrl_pkg::CONV_CTRL_RST[7:6];
      s_reg.pin_role_select   <= adc_ctrl_pkg::PIN_CFG_RST;
      s_reg.conversion_result <= adc_ctrl_pkg::RESULT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs; power stays set in the register while sleep without the rc clock shuts it off
  assign hrdata         = s_reg.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign analog_pin_en  = role_mask & (large_pkg ? 8'hFF : adc_ctrl_pkg::SMALL_PKG_MASK);  // R7 R13
  assign channel_select = s_reg.chan;                           // R6
  assign chan_present   = large_pkg || (s_reg.chan < 3'd5);     // R7
  assign ref_from_pin   = role_ref;                             // R3
  assign conv_power_on  = s_reg.power && !sleep_abort;          // R10 R24
  assign sample_hold    = (s_reg.st == adc_ctrl_pkg::ST_CONV);  // R2
  assign dac_code       = s_reg.sar;
  assign conv_irq       = s_reg.flag && s_reg.irq_en && s_reg.periph_en && s_reg.global_en;  // R18

  // helper counters for timing checks
  logic [7:0] conv_len;
  logic [7:0] hold_len;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_len <= 8'h00;
      hold_len <= 8'h00;
    end else begin
      conv_len <= (s_reg.st == adc_ctrl_pkg::ST_CONV) ? conv_len + 8'h01 : 8'h00;
      hold_len <= (s_reg.st == adc_ctrl_pkg::ST_HOLDOFF) ? hold_len + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_conv_start;
    s_reg.st == adc_ctrl_pkg::ST_IDLE ##1 s_reg.st == adc_ctrl_pkg::ST_CONV;
  endsequence
  sequence seq_done;
    done_evt;
  endsequence

  property p_start_needs_power;
    seq_conv_start |-> $past(s_reg.power) && s_reg.power;
  endproperty
  a_start_needs_power: assert property (p_start_needs_power) else $error("start without power");  // R8

  property p_conv_length;
    seq_done ##0 (s_reg.conv_clock_select == 2'h1) |-> conv_len == 8'd75;
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");  // R22

  property p_holdoff;
    $fell(s_reg.st == adc_ctrl_pkg::ST_HOLDOFF) && $past(s_reg.conv_clock_select) == 2'h1
      |-> $past(hold_len) == 8'd15;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("rest period wrong");  // R17

  property p_done_same_cycle;
    seq_done |=> !s_reg.go && s_reg.flag && s_reg.conversion_result == $past(final_code);
  endproperty
  a_done_same_cycle: assert property (p_done_same_cycle) else $error("completion not atomic");  // R25

  property p_abort_keeps;
    abort_evt |=> s_reg.conversion_result == $past(s_reg.conversion_result)
                  && s_reg.st == adc_ctrl_pkg::ST_HOLDOFF;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");  // R23

  property p_sleep_off;
    sleep_mode && s_reg.conv_clock_select != adc_ctrl_pkg::CLK_SEL_RC
      |-> !conv_power_on ##1 s_reg.st != adc_ctrl_pkg::ST_CONV;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep did not stop converter");  // R24

  property p_irq;
    seq_done ##0 (s_reg.irq_en && s_reg.periph_en && s_reg.global_en) |=> conv_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");  // R18

  property p_all_digital;
    s_reg.pin_role_select[2:1] == 2'h3 |-> analog_pin_en == 8'h00 && !ref_from_pin;
  endproperty
  a_all_digital: assert property (p_all_digital) else $error("pins not digital");  // R12

  property p_pin_cfg_read;
    taken && !hwrite && rd_idx == adc_ctrl_pkg::IDX_PIN_CFG |=> hrdata[31:3] == 29'h0;
  endproperty
  a_pin_cfg_read: assert property (p_pin_cfg_read) else $error("unimplemented bits nonzero");  // R11

  property p_small_pkg;
    !large_pkg |-> analog_pin_en[7:5] == 3'h0 && (chan_present == (channel_select < 3'd5));
  endproperty
  a_small_pkg: assert property (p_small_pkg) else $error("absent channel enabled");  // R7

  // a start always opens with the top trial bit and the sample held
  property p_start_code;
    seq_conv_start |-> dac_code == 8'h80 && sample_hold;
  endproperty
  a_start_code: assert property (p_start_code) else $error("start code wrong");  // R2

  // go can only be taken while power was already on
  property p_go_needs_power;
    $rose(s_reg.go) |-> $past(s_reg.power);
  endproperty
  a_go_needs_power: assert property (p_go_needs_power) else $error("go set without power");  // R8

  // role code zero makes every bonded pin analog with the supply reference
  property p_all_analog;
    s_reg.pin_role_select == 3'h0 && large_pkg |-> analog_pin_en == 8'hFF && !ref_from_pin;
  endproperty
  a_all_analog: assert property (p_all_analog) else $error("pins not analog");  // R12

endmodule : sar_adc_control

// ---- sar_adc_partner.sv ----
`timescale 1ns/100ps
// analog mux, sample-hold and comparator facing the converter control
module sar_adc_partner (
  input  wire logic        hclk,           // system clock
  input  wire logic [63:0] levels,         // channel n level at [8n+:8]
  input  wire logic [7:0]  analog_pin_en,  // analog routing per channel
  input  wire logic [2:0]  channel_select, // mux select
  input  wire logic        chan_present,   // channel bonded out
  input  wire logic        conv_power_on,  // converter powered
  input  wire logic        sample_hold,    // high holds the sample
  input  wire logic [7:0]  dac_code,       // trial code
  output logic             cmp_in          // input >= trial code
);
  logic [7:0] held;
  logic       live;

  initial cmp_in = 1'b0;

  // hold capacitor tracks while acquiring and keeps its level while held;
  // an unrouted, absent or unpowered input toggles so it is never trusted
  always @(posedge hclk) begin
    live = conv_power_on && chan_present && analog_pin_en[channel_select];
    if (sample_hold !== 1'b1) held <= levels[channel_select*8 +: 8];
    cmp_in <= live ? (held >= dac_code) : ~cmp_in;
  end
endmodule : sar_adc_partner

// ---- tb_sar_adc_control.sv ----
`timescale 1ns/100ps
module tb_sar_adc_control;
  localparam logic [9:0] CTL = adc_ctrl_pkg::IDX_CONV_CTRL;
  localparam logic [9:0] PCF = adc_ctrl_pkg::IDX_PIN_CFG;
  localparam logic [9:0] RES = adc_ctrl_pkg::IDX_RESULT;
  localparam logic [9:0] FLG = adc_ctrl_pkg::IDX_PERIPH_FLAG;
  localparam logic [9:0] PEN = adc_ctrl_pkg::IDX_PERIPH_EN;
  localparam logic [9:0] IRQ = adc_ctrl_pkg::IDX_IRQ_CTRL;
  localparam logic [9:0] UNM = 10'h100;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rc_clk_in = 0;
  logic        sleep_mode = 0, large_pkg = 1, cmp_in, lp;
  logic        hreadyout, hresp, chan_present, ref_from_pin, conv_power_on;
  logic        sample_hold, conv_irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, ie;
  logic [2:0]  hsize = 3'h2, ch, channel_select;
  logic [7:0]  analog_pin_en, dac_code, lvl;
  logic [63:0] levels = 0;
  logic [7:0]  role_en [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
  logic [7:0]  role_ref = 8'h2A;
  int          dur [3] = '{19, 76, 304};
  int          bad_count = 0, tests_run = 0, hold_cnt = 0, gap = 0, last_gap = 0;
  int          exp_q [$];
  int          m_res = 0;

  sar_adc_control sar_adc_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp_in(cmp_in), .rc_clk_in(rc_clk_in),
    .sleep_mode(sleep_mode), .large_pkg(large_pkg), .analog_pin_en(analog_pin_en),
    .channel_select(channel_select), .chan_present(chan_present), .ref_from_pin(ref_from_pin),
    .conv_power_on(conv_power_on), .sample_hold(sample_hold), .dac_code(dac_code), .conv_irq(conv_irq));
  sar_adc_partner sar_adc_partner_i (.hclk(hclk), .levels(levels), .analog_pin_en(analog_pin_en),
    .channel_select(channel_select), .chan_present(chan_present), .conv_power_on(conv_power_on),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in));

  // rc oscillator free runs out of phase with the system clock
  initial forever #5 hclk = ~hclk;
  initial forever #23 rc_clk_in = ~rc_clk_in;
  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  // hold length and the rest gap before the next hold
  always @(posedge hclk) begin
    if (sample_hold === 1'b1) begin
      hold_cnt <= hold_cnt + 1;
      if (gap > 0) last_gap <= gap;
      gap <= 0;
    end else gap <= gap + 1;
  end

  task automatic summarize;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask : wait_rdy

  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    // a write lands at the data edge; one more edge lets outputs show it
    if (wr) @(posedge hclk);
  endtask : xfer

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] e, input logic [31:0] m, input string nm);
    xfer(1'b0, idx, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdchk

  // poll the go flag until hardware clears it
  task automatic wait_go;
    int n;
    n = 0;
    do begin
      xfer(1'b0, CTL, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 300);
    if (rd[2] !== 1'b0) begin
      bad_count++;
      summarize();
    end
  endtask : wait_go

  task automatic start_conv(input logic [1:0] cs);
    ch  = 3'($urandom);
    lvl = 8'($urandom);
    levels[ch*8 +: 8] <= lvl;
    xfer(1'b1, CTL, 32'({cs, ch, 3'h1}));
    hold_cnt = 0;
    repeat (4) @(posedge hclk);
    xfer(1'b1, CTL, 32'({cs, ch, 3'h5}));
  endtask : start_conv

  initial begin
    void'($urandom(30230));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pin_en_rst", 32'hFF, 32'(analog_pin_en));
    chk("hresp", 32'h0, 32'(hresp));
    rdchk(CTL, 32'h0, 32'hFFFFFFFF, "ctl_rst");
    xfer(1'b1, PCF, 32'hFFFFFFFF);
    rdchk(PCF, 32'h07, 32'hFFFFFFFF, "pcfg_bits");
    xfer(1'b1, CTL, 32'hFE);
    rdchk(CTL, 32'hF8, 32'hFFFFFFFF, "go_unpowered");
    xfer(1'b1, UNM, 32'hFF);
    rdchk(UNM, 32'h0, 32'hFFFFFFFF, "unmapped");
    $display("test registers done");
    // every pin role code, each in a randomly chosen package
    for (int c = 0; c < 8; c++) begin
      lp = 1'($urandom);
      ch = 3'($urandom);
      large_pkg <= lp;
      xfer(1'b1, PCF, 32'(c));
      xfer(1'b1, CTL, 32'({ch, 3'h0}));
      chk("pin_en", 32'(role_en[c] & (lp ? 8'hFF : 8'h1F)), 32'(analog_pin_en));
      chk("ref_pin", 32'(role_ref[c]), 32'(ref_from_pin));
      chk("chan", 32'({ch, lp | (ch < 3'h5)}), 32'({channel_select, chan_present}));
    end
    large_pkg <= 1'b1;
    xfer(1'b1, PCF, 32'h0);
    xfer(1'b1, PEN, 32'h40);
    $display("test pin roles done");
    // one conversion per clock code, the rc one while asleep
    for (int k = 0; k < 4; k++) begin
      start_conv(k[1:0]);
      sleep_mode <= (k == 3);
      if (k > 0) exp_q.push_back(int'(lvl));
      wait_go();
      if (k < 3) chk("hold_len", 32'(dur[k]), 32'(hold_cnt));
      if (k > 0) begin
        m_res = exp_q.pop_front();
        rdchk(RES, 32'(m_res), 32'hFF, "result");
      end
      rdchk(FLG, 32'h40, 32'h40, "done_flag");
      ie = (k == 1) ? 2'h1 : 2'h3;
      xfer(1'b1, IRQ, 32'({ie, 6'h0}));
      chk("irq", 32'(&ie), 32'(conv_irq));
      xfer(1'b1, FLG, 32'h0);
      chk("irq_clr", 32'h0, 32'(conv_irq));
      sleep_mode <= 1'b0;
    end
    $display("test conversions done");
    // go written straight after completion waits out the rest
    start_conv(2'h1);
    wait_go();
    xfer(1'b1, CTL, 32'({2'h1, ch, 3'h5}));
    m_res = int'(lvl);
    wait_go();
    chk("rest_gap", 32'h1, 32'(last_gap >= 16));
    rdchk(RES, 32'(m_res), 32'hFF, "result_b2b");
    xfer(1'b1, FLG, 32'h0);
    $display("test rest done");
    // abort by clearing go keeps the old result and no flag
    start_conv(2'h1);
    repeat (20) @(posedge hclk);
    xfer(1'b1, CTL, 32'({2'h1, ch, 3'h1}));
    rdchk(RES, 32'(m_res), 32'hFF, "abort_res");
    rdchk(FLG, 32'h0, 32'h40, "abort_flag");
    // sleep on a system derived clock aborts and powers down
    start_conv(2'h1);
    repeat (20) @(posedge hclk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("sleep_pwr", 32'h0, 32'(conv_power_on));
    rdchk(CTL, 32'({2'h1, ch, 3'h1}), 32'hFF, "sleep_ctl");
    rdchk(RES, 32'(m_res), 32'hFF, "sleep_res");
    sleep_mode <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("pwr_on", 32'h1, 32'(conv_power_on));
    xfer(1'b1, CTL, 32'h0);
    chk("pwr_off", 32'h0, 32'(conv_power_on));
    $display("test aborts done");
    summarize();
  end
endmodule : tb_sar_adc_control
